/* File: hw/core_hazard_stall_control.sv */
// core_hazard_stall_control: checks each decoded instruction against the
// two instructions issued before it, inserts bubbles and flushes.
// assumes decoder, sequencer and dma arbiter run on core_clk.
//
// Overview of operation
// - stall the later instruction when two stages want one resource.
// - program memory bus data miss against fetch costs one stall.
// - core and dma access to one memory block costs one stall.
// - conditional store followed by any load costs one stall.
// - a reader of a value not yet produced waits until it exists.
// - float compute feeding next compute, or float multiply feeding next float compute, costs one stall.
// - conditional fixed compute right after condition set, feeding next.
// - status register write then carry or overflow user costs one stall.
// - both multiplier operands from two instructions back cost one.
// - both multiplier operands from previous instruction cost two.
// - float multiply feeding next fixed-point ALU costs nothing.
// - 64-bit float dependence costs two adjacent, one with a gap.
// - 64-bit results keep legacy latency even without a true hazard.
// - index register loaded by previous instruction stalls address use.
// - unconditional address register load then use costs four.
// - conditional address register load after condition set costs five.
// - condition set, conditional post-modify, same index use costs five.
// - immediate load of address register then use costs nothing.
// - register-write condition set or sign-extended load adds one.
// - branches, interrupts, calls, aborts flush old-flow instructions.
// - branch target buffer miss loses six, or four when delayed.

`timescale 1ns/100ps
`default_nettype none

module core_hazard_stall_control (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // decoded instruction offered for issue
  input wire hazard_pkg::instr_type dec_instr,
  // resource users outside the pipeline
  input wire logic fetch_busy,
  input wire hazard_pkg::dma_type dma_req,
  // change of flow from the sequencer
  input wire hazard_pkg::cof_type cof_req,
  // stall and flush status
  output logic hold_q,
  output logic flush_q,
  // instruction issued into execution, bubble when not valid
  output var hazard_pkg::instr_type issue_q
);

  hazard_pkg::instr_type prev_q;
  hazard_pkg::instr_type issue_d;
  hazard_pkg::instr_type pend_q;
  hazard_pkg::instr_type pend_d;
  hazard_pkg::cnt_type need;
  hazard_pkg::cnt_type stall_cnt;
  hazard_pkg::cnt_type flush_cnt;
  hazard_pkg::cnt_type stall_val;
  hazard_pkg::cnt_type flush_val;
  logic stall_load;
  logic flush_load;
  logic busy_q;
  logic busy_d;
  logic hold_d;
  logic flush_d;
  logic take;

  // true when p writes register r
  function automatic logic wr(hazard_pkg::instr_type p,
                              hazard_pkg::reg_type r);
    return p.valid && ((p.writes_a && p.dst_a == r) ||
                       (p.writes_b && p.dst_b == r));
  endfunction : wr

  // true when c reads something that p writes
  function automatic logic dep(hazard_pkg::instr_type p,
                               hazard_pkg::instr_type c);
    return (c.reads_a && wr(p, c.src_a)) || (c.reads_b && wr(p, c.src_b));
  endfunction : dep

  // true when both multiplier operands come from compute p
  function automatic logic dual(hazard_pkg::instr_type p,
                                hazard_pkg::instr_type c);
    return c.is_mul && c.reads_a && c.reads_b && p.is_compute &&
           wr(p, c.src_a) && wr(p, c.src_b);
  endfunction : dual

  function automatic hazard_pkg::cnt_type mx(hazard_pkg::cnt_type a,
                                             hazard_pkg::cnt_type b);
    return (a > b) ? a : b;
  endfunction : mx

  // address generator cost of c directly after p, q being before p
  function automatic hazard_pkg::cnt_type dag_cost(
    hazard_pkg::instr_type p, hazard_pkg::instr_type q,
    hazard_pkg::instr_type c);
    hazard_pkg::cnt_type base;
    logic extra;
    logic cond_set;
    logic same;
    base = hazard_pkg::CNT_ZERO;
    extra = 1'b0;
    cond_set = q.valid && q.sets_cond && p.is_cond;
    same = p.valid && c.dag_use && p.index_reg == c.index_reg;
    // immediate loads are ready in time and never stall
    if (same && p.dag_load && !p.dag_imm) begin
      if (cond_set) begin
        base = hazard_pkg::STALL_DAG_COND;
        extra = q.cond_regwr;
      end else begin
        base = hazard_pkg::STALL_DAG_LOAD;
      end
      extra = extra || p.dag_sext;
    end
    if (same && p.dag_postmod && cond_set) begin
      base = mx(base, hazard_pkg::STALL_DAG_POSTMOD);
      extra = extra || q.cond_regwr;
    end
    if (base != hazard_pkg::CNT_ZERO && extra) begin
      base = base + hazard_pkg::STALL_DAG_EXTRA;
    end
    return base;
  endfunction : dag_cost

  // hazard check of the offered instruction; the largest demand wins
  always_comb begin
    need = hazard_pkg::CNT_ZERO;
    if (dec_instr.valid) begin
      if (dec_instr.pm_data && dec_instr.cache_miss && fetch_busy) begin
        need = mx(need, hazard_pkg::STALL_PM_CONFLICT);
      end
      if (dec_instr.mem_acc && dma_req.valid &&
          dma_req.block == dec_instr.mem_block) begin
        need = mx(need, hazard_pkg::STALL_BLOCK_CLASH);
      end
      if (issue_q.valid && issue_q.is_store && issue_q.is_cond &&
          dec_instr.is_load) begin
        need = mx(need, hazard_pkg::STALL_COND_STORE);
      end
      // fixed-point ALU takes a float multiply result without waiting
      if (issue_q.is_fp && dec_instr.is_compute &&
          dep(issue_q, dec_instr) &&
          !(issue_q.is_mul && !dec_instr.is_fp)) begin
        need = mx(need, hazard_pkg::STALL_FP_FWD);
      end
      if (prev_q.valid && prev_q.sets_cond && issue_q.is_cond &&
          !issue_q.is_fp && dec_instr.is_compute &&
          dep(issue_q, dec_instr)) begin
        need = mx(need, hazard_pkg::STALL_COND_FWD);
      end
      if (issue_q.valid && issue_q.astat_wr && dec_instr.uses_carry) begin
        need = mx(need, hazard_pkg::STALL_ASTAT);
      end
      if (dual(prev_q, dec_instr)) begin
        need = mx(need, hazard_pkg::STALL_DUAL_GAP);
      end
      if (dual(issue_q, dec_instr)) begin
        need = mx(need, hazard_pkg::STALL_DUAL_ADJ);
      end
      if (dec_instr.is_fp64 && (issue_q.is_compute || issue_q.is_load) &&
          dep(issue_q, dec_instr)) begin
        need = mx(need, hazard_pkg::STALL_FP64_ADJ);
      end
      if (dec_instr.is_fp64 && (prev_q.is_compute || prev_q.is_load) &&
          dep(prev_q, dec_instr)) begin
        need = mx(need, hazard_pkg::STALL_FP64_GAP);
      end
      // any reader of a 64-bit result waits as older cores did
      if (issue_q.is_fp64 && dep(issue_q, dec_instr)) begin
        need = mx(need, hazard_pkg::STALL_FP64_ADJ);
      end
      if (prev_q.is_fp64 && dep(prev_q, dec_instr)) begin
        need = mx(need, hazard_pkg::STALL_FP64_GAP);
      end
      need = mx(need, dag_cost(issue_q, prev_q, dec_instr));
    end
  end

  // issue sequencing: flush first, then a held instruction, then new ones
  always_comb begin
    issue_d = hazard_pkg::INSTR_BUBBLE;
    pend_d = pend_q;
    busy_d = busy_q;
    stall_load = 1'b0;
    stall_val = hazard_pkg::CNT_ZERO;
    flush_load = 1'b0;
    flush_val = hazard_pkg::CNT_ZERO;
    if (cof_req.valid) begin
      // old-flow instruction, held or offered, is dropped
      busy_d = 1'b0;
      flush_load = 1'b1;
      if (cof_req.btb_miss) begin
        flush_val = (cof_req.delayed ? hazard_pkg::FLUSH_MISS_DELAYED :
                     hazard_pkg::FLUSH_MISS_PLAIN) - hazard_pkg::CNT_ONE;
      end else begin
        flush_val = hazard_pkg::FLUSH_OTHER - hazard_pkg::CNT_ONE;
      end
    end else if (flush_q) begin
      busy_d = 1'b0;
    end else if (busy_q) begin
      if (stall_cnt == hazard_pkg::CNT_ZERO) begin
        issue_d = pend_q;
        busy_d = 1'b0;
      end
    end else if (dec_instr.valid) begin
      if (need != hazard_pkg::CNT_ZERO) begin
        pend_d = dec_instr;
        busy_d = 1'b1;
        stall_load = 1'b1;
        stall_val = need - hazard_pkg::CNT_ONE;
      end else begin
        issue_d = dec_instr;
      end
    end
    flush_d = cof_req.valid || (flush_cnt != hazard_pkg::CNT_ZERO);
    hold_d = busy_d;
  end

  // held instruction and status flags
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pend_q <= hazard_pkg::INSTR_BUBBLE;
      busy_q <= 1'b0;
      hold_q <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      busy_q <= busy_d;
      hold_q <= hold_d;
      flush_q <= flush_d;
    end
  end

  // issued slot feeds execute; the older slot keeps the n-2 instruction
  instr_stage u_issue (
    .core_clk(core_clk),
    .rstn(rstn),
    .stage_d(issue_d),
    .stage_q(issue_q)
  );

  instr_stage u_prev (
    .core_clk(core_clk),
    .rstn(rstn),
    .stage_d(issue_q),
    .stage_q(prev_q)
  );

  // separate counters let a flush cut a stall short without a race
  down_counter u_stall_cnt (
    .core_clk(core_clk),
    .rstn(rstn),
    .load(stall_load),
    .load_val(stall_val),
    .count_q(stall_cnt)
  );

  down_counter u_flush_cnt (
    .core_clk(core_clk),
    .rstn(rstn),
    .load(flush_load),
    .load_val(flush_val),
    .count_q(flush_cnt)
  );

  // an offer is considered only when nothing older blocks it
  assign take = dec_instr.valid && !hold_q && !flush_q && !cof_req.valid;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  a_hold_bubble: assert property (hold_q |-> !issue_q.valid)
    else $error("bubble missing while an instruction is held");

  a_flush_squash: assert property (flush_q |=> !issue_q.valid)
    else $error("old-flow instruction issued during flush");

  a_pm_conflict: assert property (
    take && dec_instr.pm_data && dec_instr.cache_miss && fetch_busy
    |=> hold_q)
    else $error("no stall on program bus conflict");

  a_block_clash: assert property (
    take && dec_instr.mem_acc && dma_req.valid &&
    dma_req.block == dec_instr.mem_block |=> hold_q)
    else $error("no stall on memory block clash");

  a_cond_store: assert property (
    take && issue_q.valid && issue_q.is_store && issue_q.is_cond &&
    dec_instr.is_load |=> hold_q)
    else $error("load passed a conditional store without stall");

  a_dual_adjacent: assert property (
    take && dual(issue_q, dec_instr) && dag_cost(issue_q, prev_q,
    dec_instr) == hazard_pkg::CNT_ZERO
    |=> hold_q && stall_cnt == 3'h1 ##1 hold_q ##1 !hold_q)
    else $error("dual forward stall is not two cycles");

  a_dag_load_four: assert property (
    take && issue_q.valid && issue_q.dag_load && !issue_q.dag_imm &&
    !issue_q.is_cond && !issue_q.dag_sext && dec_instr.dag_use &&
    issue_q.index_reg == dec_instr.index_reg
    |=> hold_q && stall_cnt == 3'h3)
    else $error("address register load stall is not four cycles");

  a_clean_issue: assert property (
    take && need == hazard_pkg::CNT_ZERO
    |=> issue_q == $past(dec_instr) && !hold_q)
    else $error("hazard-free instruction did not issue next cycle");

  a_flush_miss: assert property (
    cof_req.valid && cof_req.btb_miss && !cof_req.delayed
    |=> flush_q && flush_cnt == 3'h5)
    else $error("target buffer miss flush is not six cycles");

  a_flush_delayed: assert property (
    cof_req.valid && cof_req.btb_miss && cof_req.delayed
    |=> flush_q && flush_cnt == 3'h3)
    else $error("delayed branch miss flush is not four cycles");

endmodule : core_hazard_stall_control

`default_nettype wire

/* File: hw/down_counter.sv */
// down_counter: loadable counter that falls to zero and stays there.
// assumes load has priority over counting.

`timescale 1ns/100ps
`default_nettype none

module down_counter (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // load port
  input wire logic load,
  input wire hazard_pkg::cnt_type load_val,
  // current count
  output var hazard_pkg::cnt_type count_q
);

  hazard_pkg::cnt_type count_d;

  // count down to zero, saturating there
  always_comb begin
    if (load) begin
      count_d = load_val;
    end else if (count_q != hazard_pkg::CNT_ZERO) begin
      count_d = count_q - hazard_pkg::CNT_ONE;
    end else begin
      count_d = hazard_pkg::CNT_ZERO;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      count_q <= hazard_pkg::CNT_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

endmodule : down_counter

`default_nettype wire

/* File: hw/hazard_pkg.sv */
// hazard_pkg: shared types and cycle counts for the pipeline hazard and
// stall controller and its helper modules.
// assumes one core clock; every stall and flush figure below is a count of core cycles.

package hazard_pkg;

  // width of the stall and flush down-counters
  localparam int CNT_W = 3;
  typedef logic [CNT_W-1:0] cnt_type;
  typedef logic [3:0] reg_type;
  typedef logic [2:0] idx_type;
  typedef logic [2:0] block_type;

  // structural stall counts
  localparam cnt_type STALL_PM_CONFLICT = 3'h1;
  localparam cnt_type STALL_BLOCK_CLASH = 3'h1;
  localparam cnt_type STALL_COND_STORE = 3'h1;
  // compute forwarding stall counts
  localparam cnt_type STALL_FP_FWD = 3'h1;
  localparam cnt_type STALL_COND_FWD = 3'h1;
  localparam cnt_type STALL_ASTAT = 3'h1;
  localparam cnt_type STALL_DUAL_GAP = 3'h1;
  localparam cnt_type STALL_DUAL_ADJ = 3'h2;
  localparam cnt_type STALL_FP64_ADJ = 3'h2;
  localparam cnt_type STALL_FP64_GAP = 3'h1;
  // address generator stall counts
  localparam cnt_type STALL_DAG_LOAD = 3'h4;
  localparam cnt_type STALL_DAG_COND = 3'h5;
  localparam cnt_type STALL_DAG_POSTMOD = 3'h5;
  localparam cnt_type STALL_DAG_EXTRA = 3'h1;
  // change-of-flow lost cycles
  localparam cnt_type FLUSH_MISS_PLAIN = 3'h6;
  localparam cnt_type FLUSH_MISS_DELAYED = 3'h4;
  localparam cnt_type FLUSH_OTHER = 3'h1;
  localparam cnt_type CNT_ZERO = 3'h0;
  localparam cnt_type CNT_ONE = 3'h1;

  // decoded instruction descriptor, as seen by the hazard checks
  typedef struct packed {
    logic valid;
    logic is_compute;
    logic is_fp;
    logic is_mul;
    logic is_fp64;
    logic is_load;
    logic is_store;
    logic is_cond;
    logic sets_cond;
    logic cond_regwr;
    logic astat_wr;
    logic uses_carry;
    logic pm_data;
    logic cache_miss;
    logic mem_acc;
    block_type mem_block;
    logic writes_a;
    reg_type dst_a;
    logic writes_b;
    reg_type dst_b;
    logic reads_a;
    reg_type src_a;
    logic reads_b;
    reg_type src_b;
    logic dag_load;
    logic dag_imm;
    logic dag_sext;
    logic dag_postmod;
    logic dag_use;
    idx_type index_reg;
  } instr_type;

  // background dma access to a memory block
  typedef struct packed {
    logic valid;
    block_type block;
  } dma_type;

  // change of flow from the sequencer
  typedef struct packed {
    logic valid;
    logic btb_miss;
    logic delayed;
  } cof_type;

  localparam instr_type INSTR_BUBBLE = '0;

endpackage : hazard_pkg

/* File: hw/instr_stage.sv */
// instr_stage: one pipeline slot holding an instruction descriptor.
// assumes a bubble (all zero) is a legal no-operation.

`timescale 1ns/100ps
`default_nettype none

module instr_stage (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // slot contents
  input wire hazard_pkg::instr_type stage_d,
  output var hazard_pkg::instr_type stage_q
);

  hazard_pkg::instr_type next_v;

  // slot loads every cycle; a bubble is loaded as zero
  always_comb begin
    next_v = stage_d;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      stage_q <= hazard_pkg::INSTR_BUBBLE;
    end else begin
      stage_q <= next_v;
    end
  end

endmodule : instr_stage

`default_nettype wire

/* File: verif/core_hazard_stall_control_tb.sv */
// core_hazard_stall_control_tb: offers instruction sequences and changes
// of flow, compares stall and flush lengths with a bench model.
// assumes the design alone; the bench acts as decoder and sequencer.
`timescale 1ns/100ps
`default_nettype none

module core_hazard_stall_control_tb;
  typedef hazard_pkg::instr_type ins_type;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  ins_type dec_instr = '0;
  logic fetch_busy = 1'b0;
  hazard_pkg::dma_type dma_req = '0;
  hazard_pkg::cof_type cof_req = '0;
  logic hold_q;
  logic flush_q;
  ins_type issue_q;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] lfsr_q = 32'h83b5;
  // model history: last two taken instructions
  ins_type p1 = '0;
  ins_type p2 = '0;

  // 25 MHz core clock
  always #20 core_clk = ~core_clk;

  core_hazard_stall_control u_core_hazard_stall_control (
    .core_clk(core_clk),
    .rstn(rstn),
    .dec_instr(dec_instr),
    .fetch_busy(fetch_busy),
    .dma_req(dma_req),
    .cof_req(cof_req),
    .hold_q(hold_q),
    .flush_q(flush_q),
    .issue_q(issue_q)
  );

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_errors++;
      close_out();
    end
  end

  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction : rnd

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  function automatic int mx(int a, int b);
    return (a > b) ? a : b;
  endfunction : mx

  function automatic bit hit(ins_type p, logic [3:0] r);
    return (p.writes_a && p.dst_a == r) || (p.writes_b && p.dst_b == r);
  endfunction : hit

  function automatic bit dep(ins_type p, ins_type c);
    return (c.reads_a && hit(p, c.src_a)) || (c.reads_b && hit(p, c.src_b));
  endfunction : dep

  function automatic bit dual(ins_type p, ins_type c);
    return c.is_mul && c.reads_a && c.reads_b && hit(p, c.src_a) &&
      p.is_compute && hit(p, c.src_b);
  endfunction : dual

  // stall count that the rules demand; the longest one wins
  function automatic int model_n(ins_type q1, ins_type q2, ins_type c,
      logic fb, hazard_pkg::dma_type d);
    int n;
    bit cc;
    bit same;
    n = 0;
    cc = q1.is_cond && q2.sets_cond;
    same = c.dag_use && q1.index_reg == c.index_reg;
    if (c.pm_data && c.cache_miss && fb) n = 1;
    if (c.mem_acc && d.valid && d.block == c.mem_block) n = mx(n, 1);
    if (q1.is_cond && q1.is_store && c.is_load) n = mx(n, 1);
    if (q1.is_fp && dep(q1, c) && c.is_compute && !(q1.is_mul && !c.is_fp))
      n = mx(n, 1);
    if (cc && !q1.is_fp && dep(q1, c) && c.is_compute) n = mx(n, 1);
    if (q1.astat_wr && c.uses_carry) n = mx(n, 1);
    if (dual(q2, c)) n = mx(n, 1);
    if (dual(q1, c)) n = mx(n, 2);
    if ((c.is_fp64 && (q2.is_compute || q2.is_load) || q2.is_fp64) &&
        dep(q2, c)) n = mx(n, 1);
    if ((c.is_fp64 && (q1.is_compute || q1.is_load) || q1.is_fp64) &&
        dep(q1, c)) n = mx(n, 2);
    if (q1.dag_load && !q1.dag_imm && same)
      n = mx(n, (cc ? 5 : 4) + (q1.dag_sext || (cc && q2.cond_regwr)));
    if (cc && q1.dag_postmod && same) n = mx(n, 5 + q2.cond_regwr);
    return n;
  endfunction : model_n

  function automatic ins_type op(int d, int a, int b);
    ins_type r;
    r = '0;
    r.valid = 1'b1;
    r.is_compute = (d >= 0);
    r.writes_a = (d >= 0);
    r.dst_a = d[3:0];
    r.reads_a = (a >= 0);
    r.src_a = a[3:0];
    r.reads_b = (b >= 0);
    r.src_b = b[3:0];
    return r;
  endfunction : op

  // offer at a falling edge, keep offering while held
  task automatic offer(input ins_type i, input logic fb,
      input hazard_pkg::dma_type d);
    int n;
    int cnt;
    n = model_n(p1, p2, i, fb, d);
    cnt = 0;
    dec_instr = i;
    fetch_busy = fb;
    dma_req = d;
    @(negedge core_clk);
    fetch_busy = 1'b0;
    dma_req = '0;
    while (hold_q === 1'b1 && cnt < 8) begin
      chk(issue_q.valid, 1'b0);
      cnt++;
      @(negedge core_clk);
    end
    chk(cnt, n);
    chk(issue_q, i);
    p2 = p1;
    p1 = i;
  endtask : offer

  task automatic idle(input int k);
    dec_instr = '0;
    repeat (k) begin
      @(negedge core_clk);
      p2 = p1;
      p1 = '0;
    end
  endtask : idle

  task automatic seq(input ins_type a, input ins_type b, input ins_type c,
      input logic fb, input hazard_pkg::dma_type d);
    idle(3);
    offer(a, 1'b0, '0);
    offer(b, 1'b0, '0);
    offer(c, fb, d);
  endtask : seq

  // change of flow; an offer made meanwhile must be dropped
  task automatic flush(input logic miss, input logic dl);
    int cnt;
    cnt = 0;
    cof_req = {1'b1, miss, dl};
    dec_instr = op(1, -1, -1);
    @(negedge core_clk);
    cof_req = '0;
    while (flush_q === 1'b1 && cnt < 9) begin
      chk(issue_q.valid, 1'b0);
      cnt++;
      @(negedge core_clk);
    end
    chk(cnt, miss ? (dl ? 4 : 6) : 1);
    dec_instr = '0;
    chk(issue_q.valid, 1'b0);
  endtask : flush

  // main sequence
  initial begin
    ins_type u;
    ins_type a;
    ins_type b;
    ins_type c;
    hazard_pkg::dma_type d;
    u = op(-1, -1, -1);
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    chk({hold_q, flush_q, issue_q}, '0);
    a = op(1, -1, -1);
    a.is_fp = 1'b1;
    b = op(2, 1, -1);
    b.is_fp = 1'b1;
    seq(u, a, b, 1'b0, '0);
    a.is_mul = 1'b1;
    b.is_fp = 1'b0;
    seq(u, a, b, 1'b0, '0);
    a = op(1, 3, 4);
    a.is_fp = 1'b1;
    a.writes_b = 1'b1;
    a.dst_b = 4'h2;
    b = op(5, 1, 2);
    b.is_fp = 1'b1;
    b.is_mul = 1'b1;
    seq(u, u, a, 1'b0, '0);
    offer(b, 1'b0, '0);
    seq(a, u, b, 1'b0, '0);
    a = op(3, -1, -1);
    a.is_fp = 1'b1;
    a.is_fp64 = 1'b1;
    b = a;
    b.reads_a = 1'b1;
    b.src_a = 4'h3;
    b.dst_a = 4'h6;
    seq(u, a, b, 1'b0, '0);
    seq(a, u, b, 1'b0, '0);
    a = op(5, -1, -1);
    a.sets_cond = 1'b1;
    b = op(6, 7, -1);
    b.is_cond = 1'b1;
    seq(a, b, op(8, 6, -1), 1'b0, '0);
    b = u;
    b.astat_wr = 1'b1;
    c = op(8, 7, -1);
    c.uses_carry = 1'b1;
    seq(u, b, c, 1'b0, '0);
    b = u;
    b.is_store = 1'b1;
    b.is_cond = 1'b1;
    c = u;
    c.is_load = 1'b1;
    seq(u, b, c, 1'b0, '0);
    b.is_cond = 1'b0;
    seq(u, b, c, 1'b0, '0);
    // random fetch and dma clashes
    repeat (6) begin
      c = u;
      c.pm_data = 1'b1;
      c.cache_miss = rnd() % 2;
      c.mem_acc = 1'b1;
      c.mem_block = rnd() % 8;
      d.valid = rnd() % 2;
      d.block = (rnd() % 2) ? c.mem_block : 3'(rnd() % 8);
      seq(u, u, c, rnd() % 2, d);
    end
    // address generator: plain, immediate, sign extended, conditional
    b = u;
    b.dag_load = 1'b1;
    b.index_reg = 3'h2;
    c = u;
    c.dag_use = 1'b1;
    c.index_reg = 3'h2;
    seq(u, b, c, 1'b0, '0);
    b.dag_sext = 1'b1;
    seq(u, b, c, 1'b0, '0);
    b.is_cond = 1'b1;
    seq(a, b, c, 1'b0, '0);
    b.dag_sext = 1'b0;
    seq(a, b, c, 1'b0, '0);
    a.cond_regwr = 1'b1;
    seq(a, b, c, 1'b0, '0);
    b.dag_imm = 1'b1;
    b.is_cond = 1'b0;
    seq(u, b, c, 1'b0, '0);
    b = u;
    b.is_cond = 1'b1;
    b.dag_postmod = 1'b1;
    b.index_reg = 3'h2;
    a.cond_regwr = 1'b0;
    seq(a, b, c, 1'b0, '0);
    for (int k = 0; k < 3; k++) begin
      idle(2);
      flush(k != 2, k == 1);
    end
    idle(3);
    close_out();
  end
endmodule : core_hazard_stall_control_tb

`default_nettype wire
